// ==== hw/dpf_core.sv ====
// Purpose: NCO phase offset, fractional delay and decimating mixer with APB registers
// Assumes: one ADC sample per valid cycle; link transmitter takes iq_out
// Notes: zero-wait APB slave, unmapped addresses answer with pslverr
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
// Notes on behaviour
// - Offset MSB-justified, added to accumulator
// - Offset weight is 2^-16 of a turn
// - Signed or unsigned offset, same phase
// - Each delay step is half a sample
// - All-ones delay bypasses filter, 34 less
// - Delay setting kept per preset
// - Output is 15-bit I and Q
// - Decimation factors four to thirty-two
// - Decimated samples go to link transmitter
// - 32-bit tuning word accumulated per sample
// - Tuning change on live link: phase nondeterministic
module dpf_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dpf_pkg::dpf_adc_t adc_in,
  input wire logic link_active,
  input wire logic link_init,
  output dpf_pkg::dpf_iq_t iq_out
);
  import dpf_pkg::*;

  dpf_preset_t pre_reg [NPRE];
  logic [1:0] act_reg;
  logic nondet_reg;
  logic [31:0] acc_reg;
  logic [MEM_AW-1:0] wptr_reg;
  logic [5:0] cnt_reg;
  logic signed [24:0] sum_i_reg;
  logic signed [24:0] sum_q_reg;
  logic signed [ADC_W-1:0] dmem [2**MEM_AW];
  logic [31:0] rd_data;

  // Bus decode
  wire logic setup = psel & ~penable;
  wire logic acc_en = psel & penable & pready;
  wire logic wr_en = acc_en & pwrite;
  wire logic in_pre = (paddr[7:6] == 2'b00);
  wire logic [1:0] sel_pre = paddr[5:4];
  wire logic [3:0] sub = paddr[3:0];
  wire logic mapped = (paddr[1:0] == 2'b00) & (in_pre | paddr == A_CTRL | paddr == A_STAT);
  wire logic wr_freq = wr_en & in_pre & (sub == A_FREQ);

  // Settings of the preset in use
  wire dpf_preset_t cur = pre_reg[act_reg];
  wire logic [5:0] dec_eff = (cur.dec < DEC_MIN) ? DEC_MIN :
    (cur.dec > DEC_MAX) ? DEC_MAX : cur.dec;
  wire logic bypass = (cur.dly == DLY_BYPASS);

  always_comb
  begin
    rd_data = 32'h00000000;
    if (in_pre)
    begin
      unique case (sub)
        A_FREQ: rd_data = pre_reg[sel_pre].freq;
        A_PHASE: rd_data = {16'h0000, pre_reg[sel_pre].phase};
        A_DLY: rd_data = {24'h000000, pre_reg[sel_pre].dly};
        A_DEC: rd_data = {26'h0000000, pre_reg[sel_pre].dec};
        default: rd_data = 32'h00000000;
      endcase
    end
    else if (paddr == A_CTRL)
      rd_data = {30'h0, act_reg};
    else if (paddr == A_STAT)
      rd_data = {31'h0, nondet_reg};
  end

  // Answer in the first access cycle; data captured at setup
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= mapped ? rd_data : 32'h00000000;
    end
  end

  for (genvar p = 0; p < NPRE; p++)
  begin : g_pre
    wire logic hit = wr_en & in_pre & (sel_pre == 2'(p));
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        pre_reg[p] <= '{FREQ_RST, PHASE_RST, DLY_RST, DEC_RST};
      else if (hit)
      begin
        unique case (sub)
          A_FREQ: pre_reg[p].freq <= pwdata;
          A_PHASE: pre_reg[p].phase <= pwdata[15:0];
          A_DLY: pre_reg[p].dly <= pwdata[7:0];
          A_DEC: pre_reg[p].dec <= pwdata[5:0];
          default: ;
        endcase
      end
    end
  end

  // Set wins over both clears so a late tuning write is never lost
  wire logic nondet_set = wr_freq & link_active;
  wire logic nondet_clr = link_init | (wr_en & paddr == A_STAT & pwdata[0]);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      act_reg <= 2'b00;
      nondet_reg <= 1'b0;
    end
    else
    begin
      if (wr_en & paddr == A_CTRL)
        act_reg <= pwdata[1:0];
      if (nondet_set)
        nondet_reg <= 1'b1;
      else if (nondet_clr)
        nondet_reg <= 1'b0;
    end
  end

  // Fractional delay: fixed 34-sample filter latency plus half-sample steps
  wire logic [MEM_AW-1:0] ra0 = wptr_reg - FILT_LAT - cur.dly[7:1];
  wire logic [MEM_AW-1:0] ra1 = ra0 - 7'h01;
  wire logic signed [ADC_W-1:0] x0 = dmem[ra0];
  wire logic signed [ADC_W-1:0] x1 = dmem[ra1];
  wire logic signed [ADC_W:0] xsum = {x0[ADC_W-1], x0} + {x1[ADC_W-1], x1};
  wire logic signed [ADC_W-1:0] frac_x = cur.dly[0] ? xsum[ADC_W:1] : x0;
  wire logic signed [ADC_W-1:0] mix_x = bypass ? adc_in.data : frac_x;
  wire logic dl_en = adc_in.valid & ~bypass;

  // Memory idles in bypass, standing in for filter power-down
  always_ff @(posedge clk)
  begin
    if (dl_en)
      dmem[wptr_reg] <= adc_in.data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wptr_reg <= '0;
    else if (dl_en)
      wptr_reg <= wptr_reg + 7'h01;
  end

  // Quarter-wave table, 7-bit magnitude
  function automatic logic signed [7:0] lut(input logic [5:0] p);
    logic [4:0] k;
    logic [6:0] m;
    k = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
    unique case (k)
      5'h00: m = 7'h00;
      5'h01: m = 7'h0C;
      5'h02: m = 7'h19;
      5'h03: m = 7'h25;
      5'h04: m = 7'h31;
      5'h05: m = 7'h3C;
      5'h06: m = 7'h47;
      5'h07: m = 7'h51;
      5'h08: m = 7'h5A;
      5'h09: m = 7'h62;
      5'h0A: m = 7'h6A;
      5'h0B: m = 7'h70;
      5'h0C: m = 7'h75;
      5'h0D: m = 7'h7A;
      5'h0E: m = 7'h7D;
      5'h0F: m = 7'h7E;
      default: m = 7'h7F;
    endcase
    return p[5] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  // Offset word sits in the top half; modular add makes sign irrelevant
  wire logic [31:0] phase_tot = acc_reg + {cur.phase, 16'h0000};
  wire logic [5:0] p6 = phase_tot[31:26];
  wire logic signed [7:0] cos_v = lut(p6 + 6'h10);
  wire logic signed [7:0] sin_v = lut(p6);
  wire logic signed [19:0] prod_i = 20'(mix_x) * 20'(cos_v);
  wire logic signed [19:0] prod_q = -(20'(mix_x) * 20'(sin_v));
  wire logic signed [24:0] nxt_i = sum_i_reg + 25'(prod_i);
  wire logic signed [24:0] nxt_q = sum_q_reg + 25'(prod_q);
  // Compare with >= so a preset switch to a smaller factor still dumps at once
  wire logic dump = adc_in.valid & (cnt_reg >= dec_eff - 6'h01);

  // Re-initialising the link restarts the oscillator from zero phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      acc_reg <= 32'h00000000;
    else if (link_init)
      acc_reg <= 32'h00000000;
    else if (adc_in.valid)
      acc_reg <= acc_reg + cur.freq;
  end

  // Integrate and dump over D samples
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 6'h00;
      sum_i_reg <= '0;
      sum_q_reg <= '0;
      iq_out <= '0;
    end
    else
    begin
      iq_out.valid <= dump;
      if (dump)
      begin
        cnt_reg <= 6'h00;
        sum_i_reg <= '0;
        sum_q_reg <= '0;
        iq_out.i <= nxt_i[OUT_LSB+OUT_W-1:OUT_LSB];
        iq_out.q <= nxt_q[OUT_LSB+OUT_W-1:OUT_LSB];
      end
      else if (adc_in.valid)
      begin
        cnt_reg <= cnt_reg + 6'h01;
        sum_i_reg <= nxt_i;
        sum_q_reg <= nxt_q;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_live_tune;
    wr_freq && link_active;
  endsequence

  sequence s_flag_up;
    nondet_reg [*2];
  endsequence

  chk_nco_step: assert property (
    adc_in.valid && !link_init |=> acc_reg == $past(acc_reg) + $past(cur.freq))
    else $error("oscillator accumulator did not advance by tuning word");

  chk_link_init: assert property (
    link_init && !nondet_set |=> acc_reg == 32'h00000000 && !nondet_reg)
    else $error("link init did not restart oscillator");

  chk_nondet_set: assert property (
    s_live_tune ##1 !link_init |-> s_flag_up)
    else $error("live tuning change not flagged");

  chk_offset_msb: assert property (
    phase_tot[15:0] == acc_reg[15:0] && (acc_reg != 32'h00000000 || p6 == cur.phase[15:10]))
    else $error("phase offset not placed in upper half");

  chk_offset_turn: assert property (
    acc_reg == 32'h00000000 && cur.phase == 16'h4000 |-> sin_v == 8'sh7F && cos_v == 8'sh00)
    else $error("quarter-turn offset gave wrong phase");

  chk_bypass_gate: assert property (
    bypass && adc_in.valid |=> wptr_reg == $past(wptr_reg))
    else $error("delay memory ran while bypassed");

  chk_half_step: assert property (
    !bypass && cur.dly[0] |-> ra0 - ra1 == 7'h01 && wptr_reg - ra0 == FILT_LAT + cur.dly[7:1])
    else $error("fractional delay taps misplaced");

  chk_dec_range: assert property (
    dec_eff >= DEC_MIN && dec_eff <= DEC_MAX && cnt_reg < DEC_MAX)
    else $error("decimation factor out of range");

  chk_out_valid: assert property (
    iq_out.valid |-> $past(adc_in.valid) && $past(cnt_reg) >= $past(dec_eff) - 6'h01)
    else $error("output sample not at decimation boundary");

  chk_apb_answer: assert property (
    setup |=> pready && (pslverr == !$past(mapped)))
    else $error("bus answer missing or wrong");
endmodule

// ==== hw/dpf_pkg.sv ====
// Purpose: shared constants and carriers for the down converter phase/delay block
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes: preset p occupies bytes 0x10*p .. 0x10*p+0xC
package dpf_pkg;
  localparam int ADC_W = 12;
  localparam int OUT_W = 15;
  localparam int NPRE = 4;
  localparam int MEM_AW = 7;
  localparam logic [7:0] A_CTRL = 8'h40;
  localparam logic [7:0] A_STAT = 8'h44;
  localparam logic [3:0] A_FREQ = 4'h0;
  localparam logic [3:0] A_PHASE = 4'h4;
  localparam logic [3:0] A_DLY = 4'h8;
  localparam logic [3:0] A_DEC = 4'hC;
  localparam logic [31:0] FREQ_RST = 32'hC0000000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [7:0] DLY_RST = 8'hFF;
  localparam logic [7:0] DLY_BYPASS = 8'hFF;
  localparam logic [5:0] DEC_RST = 6'h04;
  localparam logic [5:0] DEC_MIN = 6'h04;
  localparam logic [5:0] DEC_MAX = 6'h20;
  localparam logic [6:0] FILT_LAT = 7'h22;
  localparam int OUT_LSB = 10;

  typedef struct packed {
    logic valid;
    logic signed [ADC_W-1:0] data;
  } dpf_adc_t;

  typedef struct packed {
    logic valid;
    logic signed [OUT_W-1:0] i;
    logic signed [OUT_W-1:0] q;
  } dpf_iq_t;

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [7:0] dly;
    logic [5:0] dec;
  } dpf_preset_t;
endpackage

// ==== verification/dpf_sink.sv ====
// Purpose: downstream capture device, records decimated samples
// Assumes: iq_out registered, valid a one-cycle pulse
// Notes: link has no back-pressure, so the sink only listens
`timescale 1ns/10ps
module dpf_sink
  import dpf_pkg::*;
(
  input wire logic clk,
  input wire dpf_pkg::dpf_iq_t iq,
  output logic signed [OUT_W-1:0] last_i,
  output logic signed [OUT_W-1:0] last_q
);
  always @(posedge clk)
    if (iq.valid === 1'b1)
    begin
      last_i <= iq.i;
      last_q <= iq.q;
    end
endmodule

// ==== verification/test_ddc_phase_offset_fine_delay.sv ====
// Purpose: self-checking bench for the phase offset and fine delay block
// Assumes: zero-wait APB slave, constant input level 100
// Notes: latency runs first align the decimation count on a dump
`timescale 1ns/10ps
module test_ddc_phase_offset_fine_delay;
  import dpf_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic e;} dpf_row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er, link_active, link_init;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  dpf_adc_t adc_in;
  dpf_iq_t iq_out;
  logic signed [OUT_W-1:0] last_i, last_q;
  int err_total, samples_checked, cyc, n;
  dpf_row_t rows [9];
  dpf_core i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_in(adc_in), .link_active(link_active), .link_init(link_init), .iq_out(iq_out));
  dpf_sink i_sink (.clk(clk), .iq(iq_out), .last_i(last_i), .last_q(last_q));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t word %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_iq(input logic signed [OUT_W-1:0] g, input int e);
    samples_checked++;
    if (g !== OUT_W'(e))
    begin
      err_total++;
      $display("[ERR] %0t sample %0d want %0d", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse_init();
    @(posedge clk);
    link_init <= 1'b1;
    @(posedge clk);
    link_init <= 1'b0;
  endtask
  task automatic feed(input logic [11:0] x, input int cnt);
    repeat (cnt)
    begin
      @(posedge clk);
      adc_in <= '{1'b1, x};
    end
    @(posedge clk);
    adc_in.valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Preset p: zero tuning word, offset ph, factor d, bypass delay
  task automatic steady(input logic [7:0] b, input logic [31:0] ph, input int d, ci, cq);
    apb(1'b1, b, 32'h0);
    apb(1'b1, b + 8'h04, ph);
    apb(1'b1, b + 8'h0C, d);
    apb(1'b1, A_CTRL, b >> 4);
    pulse_init();
    feed(12'h064, 3 * d);
    chk_iq(last_i, (ci * 12700 * d) >>> 10);
    chk_iq(last_q, (cq * 12700 * d) >>> 10);
  endtask
  task automatic lat(input logic [1:0] p, input int lo, input int v);
    apb(1'b1, A_CTRL, p);
    feed(12'h000, 48);
    do
    begin
      @(posedge clk);
      adc_in <= '{1'b1, 12'h000};
      @(negedge clk);
    end while (iq_out.valid !== 1'b1);
    n = 0;
    do
    begin
      @(posedge clk);
      adc_in <= '{1'b1, 12'h064};
      n++;
      @(negedge clk);
    end while (!(iq_out.valid === 1'b1 && iq_out.i > 0) && n < 80);
    chk_word(32'(n), 32'(lo));
    chk_iq(iq_out.i, v);
    @(posedge clk);
    adc_in.valid <= 1'b0;
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, link_active, link_init} = '0;
    adc_in = '0;
    rst = 1'b1;
    rows = '{'{1'b0, 8'h00, 32'hC000_0000, 1'b0}, '{1'b0, 8'h04, 32'h0, 1'b0},
      '{1'b0, 8'h08, 32'hFF, 1'b0}, '{1'b0, 8'h3C, 32'h4, 1'b0},
      '{1'b0, A_CTRL, 32'h0, 1'b0}, '{1'b0, 8'h48, 32'h0, 1'b1},
      '{1'b0, 8'h01, 32'h0, 1'b1}, '{1'b1, 8'h14, 32'hFFFF_1234, 1'b0},
      '{1'b0, 8'h14, 32'h1234, 1'b0}};
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_word({prdata[30:0], pready}, 32'h0);
    chk_iq(iq_out.i, 0);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    $display("test reset done");
    foreach (rows[k])
    begin
      apb(rows[k].wr, rows[k].a, rows[k].d);
      chk_word(32'(er), 32'(rows[k].e));
      if (!rows[k].wr)
        chk_word(rd, rows[k].d);
    end
    $display("test registers done");
    steady(8'h00, 32'h0, 4, 1, 0);
    steady(8'h20, 32'h4000, 4, 0, -1);
    steady(8'h30, 32'hC000, 32, 0, 1);
    $display("test phase done");
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h18, 32'h0);
    lat(2'h0, 4, 37);
    lat(2'h1, 36, 11);
    apb(1'b1, 8'h18, 32'h1);
    lat(2'h1, 36, 5);
    $display("test latency done");
    @(posedge clk);
    link_active <= 1'b1;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk_word(rd, 32'h1);
    apb(1'b1, A_STAT, 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    pulse_init();
    apb(1'b0, A_STAT, 32'h0);
    chk_word(rd, 32'h0);
    $display("test status done");
    give_verdict();
  end
endmodule
